/* hw/rgb_pwm_defs.svh */
// Constants for the three-channel brightness-modulated PWM generator
`ifndef RGB_PWM_DEFS_SVH
`define RGB_PWM_DEFS_SVH
`define TICK_CYCLES 16'h00C8
`define LEVEL_TOP_RST 4'h8
`define BRIGHT_TOP_RST 8'h32
`define LEVEL_ZERO 4'h0
`define BRIGHT_ZERO 8'h00
`define TICK_ZERO 16'h0000
`define TICK_ONE 16'h0001
`define LEVEL_ONE 4'h1
`define BRIGHT_ONE 8'h01
`define CHAN_RED 0
`define CHAN_GREEN 1
`define CHAN_BLUE 2
`endif

/* hw/rgb_pwm_pkg.sv */
// Types for the three-channel brightness-modulated PWM generator
package rgb_pwm_pkg;
  typedef struct packed {
    logic [3:0] red;
    logic [3:0] green;
    logic [3:0] blue;
  } color_s;
  typedef struct packed {
    color_s color;
    logic [7:0] brightness;
    logic [3:0] levelTop;
    logic [7:0] brightTop;
  } setting_s;
endpackage : rgb_pwm_pkg

/* hw/rgb_brightness_pwm.sv */
// Three-channel PWM generator with a shared brightness gate
// Overview of operation
// - Each channel intensity is set only by its output duty cycle.
// - Outputs are active low; low lights the LED, high darkens it.
// - One brightness gate applies identically to all three channels.
// - Level counter increments per tick, wraps to zero past its top.
// - Compare sets duty, level top sets period, independently.
// - All channels share one level counter, each with own compare.
// - On level wrap every output with a nonzero level turns on unless the gate forces off.
// - Channel on until count equals its level; full level stays on.
// - Brightness counter increments once per level counter wrap.
// - At brightness threshold all outputs off until brightness wraps.
// - After brightness wrap, outputs follow level comparisons again.
// - Level top 5 counts 0..5, six steps; counters start at zero.
// - Brightness top 7 counts 0..7, eight level periods.
// - Output and brightness rates should exceed 50 Hz.
// - Default level full scale 8, brightness full scale 50.
// - Counter tick every 200 system clock cycles.
// - Applying new settings clears counters and darkens outputs first.
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "rgb_pwm_defs.svh"
module rgb_brightness_pwm #(
  parameter logic [15:0] TICK_CYCLES = `TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Settings
  input wire rgb_pwm_pkg::setting_s setting,
  input wire logic applyStrobe,
  input wire logic runEnable,
  // Register port
  input wire logic [1:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regRdata,
  // LED switch drives, active low
  output logic redDriveN,
  output logic greenDriveN,
  output logic blueDriveN,
  // Status
  output logic [3:0] levelCount,
  output logic [7:0] brightCount
);
  import rgb_pwm_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LOAD = 3'b010,
    ST_RUN = 3'b100
  } gen_state_e;

  gen_state_e state;
  gen_state_e next_state;
  setting_s active;
  logic [15:0] tickCount;
  logic tick;
  logic levelWrap;
  logic brightWrap;
  logic gateOff;
  logic [2:0] chanOn;
  logic [3:0] chanLevel [3];
  logic applyReq;
  logic regEnable;
  logic allDark;
  logic runOn;
  logic [15:0] tickSpacing;
  logic tickArmed;

  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  // Register 0: control (bit0 enable, bit1 apply); 1: counters; 2: state
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      regEnable <= 1'b0;
    else if (regWrite && regAddr == 2'h0)
      regEnable <= regWdata[0];
  end

  assign applyReq = applyStrobe | (regWrite && regAddr == 2'h0
    && regWdata[1]);

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      regRdata <= 16'h0000;
    else if (regRead)
    begin
      unique case (regAddr)
        2'h0: regRdata <= {14'h0000, 1'b0, regEnable};
        2'h1: regRdata <= {4'h0, levelCount, brightCount};
        2'h2: regRdata <= {13'h0000, state};
        default: regRdata <= 16'h0000;
      endcase
    end
  end

  // Generation sequencer
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE:
      begin
        if (applyReq)
          next_state = ST_LOAD;
        else if (runEnable || regEnable)
          next_state = ST_RUN;
      end
      ST_LOAD:
        next_state = ST_IDLE;
      ST_RUN:
      begin
        if (applyReq)
          next_state = ST_LOAD;
        else if (!(runEnable || regEnable))
          next_state = ST_IDLE;
      end
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // Active settings, captured on apply
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      active.color <= '0;
      active.brightness <= `BRIGHT_ZERO;
      active.levelTop <= `LEVEL_TOP_RST;
      active.brightTop <= `BRIGHT_TOP_RST;
    end
    else if (applyReq)
      active <= setting;
  end

  // Constant-rate tick
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      tickCount <= `TICK_ZERO;
    else if (state != ST_RUN || tick)
      tickCount <= `TICK_ZERO;
    else
      tickCount <= tickCount + `TICK_ONE;
  end

  assign tick = (state == ST_RUN) && (tickCount == TICK_CYCLES - `TICK_ONE);
  assign levelWrap = tick && (levelCount >= active.levelTop);
  assign brightWrap = levelWrap && (brightCount >= active.brightTop);

  // Shared level counter
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      levelCount <= `LEVEL_ZERO;
    else if (state != ST_RUN)
      levelCount <= `LEVEL_ZERO;
    else if (levelWrap)
      levelCount <= `LEVEL_ZERO;
    else if (tick)
      levelCount <= levelCount + `LEVEL_ONE;
  end

  // Brightness counter
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      brightCount <= `BRIGHT_ZERO;
    else if (state != ST_RUN)
      brightCount <= `BRIGHT_ZERO;
    else if (brightWrap)
      brightCount <= `BRIGHT_ZERO;
    else if (levelWrap)
      brightCount <= brightCount + `BRIGHT_ONE;
  end

  assign gateOff = brightCount >= active.brightness;

  assign chanLevel[`CHAN_RED] = active.color.red;
  assign chanLevel[`CHAN_GREEN] = active.color.green;
  assign chanLevel[`CHAN_BLUE] = active.color.blue;

  // Per-channel compare against shared count
  for (genvar c = 0; c < 3; c++)
  begin : g_chan
    assign chanOn[c] = (state == ST_RUN) && !gateOff
      && (levelCount < chanLevel[c]);
  end

  // Active-low drives, registered
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      redDriveN <= 1'b1;
      greenDriveN <= 1'b1;
      blueDriveN <= 1'b1;
    end
    else
    begin
      redDriveN <= ~chanOn[`CHAN_RED];
      greenDriveN <= ~chanOn[`CHAN_GREEN];
      blueDriveN <= ~chanOn[`CHAN_BLUE];
    end
  end

  // Checker helpers, read only by the assertions below
  assign allDark = redDriveN && greenDriveN && blueDriveN;
  assign runOn = runEnable || regEnable;

  // Free count of cycles between two ticks
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      tickSpacing <= `TICK_ZERO;
    else if (tick)
      tickSpacing <= `TICK_ZERO;
    else
      tickSpacing <= tickSpacing + `TICK_ONE;
  end

  // Armed after a tick, dropped whenever generation stops
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      tickArmed <= 1'b0;
    else if (state != ST_RUN)
      tickArmed <= 1'b0;
    else if (tick)
      tickArmed <= 1'b1;
  end

  // Apply handling steps
  sequence s_apply_taken;
    applyReq && state != ST_LOAD;
  endsequence

  sequence s_load_idle;
    state == ST_LOAD ##1 state == ST_IDLE;
  endsequence

  sequence s_cleared;
    levelCount == `LEVEL_ZERO && brightCount == `BRIGHT_ZERO
      && allDark;
  endsequence

  a_gate_dark: assert property (gateOff
    |=> allDark)
    else $error("outputs lit while brightness gate closed");

  a_level_wrap: assert property (levelWrap && !applyReq && runOn
    |=> levelCount == `LEVEL_ZERO)
    else $error("level counter did not wrap to zero");

  a_level_step: assert property (
    tick && !levelWrap && !applyReq && runOn
    |=> levelCount == $past(levelCount) + `LEVEL_ONE)
    else $error("level counter did not step on tick");

  a_level_bound: assert property (state == ST_RUN
    |-> levelCount <= active.levelTop)
    else $error("level counter passed its top");

  a_bright_step: assert property (
    levelWrap && !brightWrap && !applyReq && runOn
    |=> brightCount == $past(brightCount) + `BRIGHT_ONE)
    else $error("brightness counter missed a level wrap");

  a_bright_hold: assert property (
    tick && !levelWrap && !applyReq && runOn
    |=> $stable(brightCount))
    else $error("brightness counter moved without a level wrap");

  a_bright_wrap: assert property (brightWrap && !applyReq && runOn
    |=> brightCount == `BRIGHT_ZERO)
    else $error("brightness counter did not wrap");

  a_bright_bound: assert property (state == ST_RUN
    |-> brightCount <= active.brightTop)
    else $error("brightness counter passed its top");

  a_apply_load: assert property (s_apply_taken
    |=> s_load_idle)
    else $error("apply did not pass through the load step");

  a_apply_clear: assert property (applyReq
    |=> ##1 s_cleared)
    else $error("apply did not clear counters and outputs");

  a_apply_capture: assert property (applyReq
    |=> active == $past(setting))
    else $error("apply did not capture the new settings");

  a_red_compare: assert property (state == ST_RUN
    |=> redDriveN == !(!$past(gateOff)
    && $past(levelCount) < $past(active.color.red)))
    else $error("red output disagrees with compare");

  a_green_compare: assert property (state == ST_RUN
    |=> greenDriveN == !(!$past(gateOff)
    && $past(levelCount) < $past(active.color.green)))
    else $error("green output disagrees with compare");

  a_blue_compare: assert property (state == ST_RUN
    |=> blueDriveN == !(!$past(gateOff)
    && $past(levelCount) < $past(active.color.blue)))
    else $error("blue output disagrees with compare");

  a_idle_dark: assert property (state != ST_RUN
    |=> allDark)
    else $error("outputs lit while generation stopped");

  a_tick_rate: assert property (tick && tickArmed
    |-> tickSpacing == TICK_CYCLES - `TICK_ONE)
    else $error("tick spacing differs from the tick period");

  a_tick_idle: assert property (state != ST_RUN
    |=> tickCount == `TICK_ZERO)
    else $error("tick divider ran while generation stopped");

  a_read_control: assert property (regRead && regAddr == 2'h0
    |=> regRdata == {15'h0000, $past(regEnable)})
    else $error("control read returned wrong data");

  a_read_status: assert property (regRead && regAddr == 2'h1
    |=> regRdata == {4'h0, $past(levelCount),
    $past(brightCount)})
    else $error("status read returned wrong data");

  a_read_state: assert property (regRead && regAddr == 2'h2
    |=> regRdata == {13'h0000, $past(state)})
    else $error("state read returned wrong data");

  a_enable_write: assert property (regWrite && regAddr == 2'h0
    |=> regEnable == $past(regWdata[0]))
    else $error("enable bit did not follow the control write");
endmodule : rgb_brightness_pwm

/* testbench/led_switch_model.sv */
// Model of one P-FET LED switch with a weak gate pull-up
`timescale 1ns/1ps
module led_switch_model (
  // Gate drive
  input wire logic gateN,
  // LED state
  output logic ledOn
);
  tri1 gate;
  assign gate = gateN;
  assign ledOn = (gate === 1'b0);
endmodule : led_switch_model

/* testbench/tb_rgb_brightness_pwm.sv */
// Self-checking bench for the brightness-modulated PWM generator
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errCount++; \
  $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module tb_rgb_brightness_pwm;
  import rgb_pwm_pkg::*;
  localparam logic [15:0] TICK = 16'h0004;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic applyStrobe = 1'b0;
  logic runEnable = 1'b0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [1:0] regAddr = 2'h0;
  logic [15:0] regWdata = 16'h0000;
  logic [15:0] regRdata;
  setting_s setting = '0;
  logic redDriveN, greenDriveN, blueDriveN;
  logic [3:0] levelCount;
  logic [7:0] brightCount;
  logic [2:0] ledOn;
  int errCount = 0;
  int comparisons = 0;
  int lv[3];
  int bri, lTop, bTop, pL, pB, gap;
  bit chkOn = 1'b0;
  rgb_brightness_pwm #(.TICK_CYCLES(TICK)) DUT (.clk_sys(clk_sys),
    .resetn(resetn), .setting(setting), .applyStrobe(applyStrobe),
    .runEnable(runEnable), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .redDriveN(redDriveN), .greenDriveN(greenDriveN),
    .blueDriveN(blueDriveN), .levelCount(levelCount),
    .brightCount(brightCount));
  led_switch_model LED[2:0] (.gateN({blueDriveN, greenDriveN, redDriveN}),
    .ledOn(ledOn));
  initial
  begin
    forever #4 clk_sys = ~clk_sys;
  end
  // Reference counters predicted from the previous sample
  always @(posedge clk_sys)
  begin
    #1;
    if (gap >= 0)
      gap++;
    if (chkOn)
    begin
      `CHK(ledOn, {pB < bri && pL < lv[2], pB < bri && pL < lv[1], pB < bri && pL < lv[0]})
      if (levelCount !== pL)
      begin
        `CHK(levelCount, (pL == lTop) ? 0 : pL + 1)
        `CHK(brightCount, (pL != lTop) ? pB : (pB == bTop) ? 0 : pB + 1)
        if (gap >= 0)
          `CHK(gap, TICK)
        gap = 0;
      end
      else
        `CHK(brightCount, pB)
    end
    pL = levelCount;
    pB = brightCount;
  end
  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", comparisons, errCount);
    if (errCount == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  task automatic regWr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask : regWr
  task automatic regRd(input logic [1:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1 `CHK(regRdata, e)
  endtask : regRd
  task automatic idleCheck;
    #1 `CHK({levelCount, brightCount}, 12'h000)
    `CHK({redDriveN, greenDriveN, blueDriveN}, 3'h7)
  endtask : idleCheck
  task automatic apply(input setting_s s, input bit viaReg);
    chkOn = 1'b0;
    lv = '{s.color.red, s.color.green, s.color.blue};
    bri = s.brightness;
    lTop = s.levelTop;
    bTop = s.brightTop;
    gap = -1;
    setting <= s;
    if (viaReg)
      regWr(2'h0, 16'h0003);
    else
    begin
      @(posedge clk_sys);
      applyStrobe <= 1'b1;
      @(posedge clk_sys);
      applyStrobe <= 1'b0;
    end
    repeat (2) @(posedge clk_sys);
    idleCheck();
    repeat (3) @(posedge clk_sys);
    chkOn = 1'b1;
    repeat ((lTop + 1) * (bTop + 1) * TICK * 2) @(posedge clk_sys);
  endtask : apply
  initial
  begin
    #400000;
    errCount++;
    conclude();
  end
  initial
  begin
    setting_s s;
    void'($urandom(32'h24ac_b6cc));
    repeat (16) @(posedge clk_sys);
    idleCheck();
    resetn <= 1'b1;
    regRd(2'h0, 16'h0000);
    regRd(2'h2, 16'h0001);
    regRd(2'h3, 16'h0000);
    $display("Test reset done");
    runEnable <= 1'b1;
    apply('{'{4'h3, 4'h6, 4'h2}, 8'h04, 4'h5, 8'h07}, 1'b0);
    chkOn = 1'b0;
    runEnable <= 1'b0;
    repeat (3) @(posedge clk_sys);
    idleCheck();
    $display("Test six-step example done");
    repeat (3)
    begin
      s.levelTop = $urandom_range(8, 1);
      s.brightTop = $urandom_range(9, 1);
      s.color.red = $urandom_range(s.levelTop + 1, 0);
      s.color.green = $urandom_range(s.levelTop + 1, 0);
      s.color.blue = $urandom_range(s.levelTop + 1, 0);
      s.brightness = $urandom_range(s.brightTop + 1, 0);
      apply(s, 1'b1);
      regRd(2'h0, 16'h0001);
      regRd(2'h2, 16'h0004);
      $display("Test random setting done");
    end
    chkOn = 1'b0;
    regWr(2'h0, 16'h0000);
    repeat (3) @(posedge clk_sys);
    idleCheck();
    regRd(2'h1, 16'h0000);
    $display("Test register stop done");
    conclude();
  end
endmodule : tb_rgb_brightness_pwm
